// [hdl/sba_pkg.sv]
/*
  Shared constants for the system bus arbiter and its configuration end.
  Assumes one 10 MHz clock (hclk) and one asynchronous active-low reset.
*/
package sba_pkg;
  // Master count and priority order (index 0 wins)
  localparam int unsigned NUM_M        = 3;
  localparam int unsigned M_CORE       = 0;
  localparam int unsigned M_DMA        = 1;
  localparam int unsigned M_HOST       = 2;

  // arbiter_config_reg field layout
  localparam int unsigned ACR_ARB_LSB   = 10;
  localparam int unsigned ACR_DEPTH_LSB = 16;
  localparam int unsigned ACR_HOLD_BIT  = 20;
  localparam logic [31:0] ACR_RST       = 32'h0000_0000;
  localparam logic [1:0]  ARB_RATIO_LOW = 2'h2;   // 1:1 and 1:1.5
  localparam logic [1:0]  ARB_RATIO_HIGH = 2'h1;  // 1:2 and above

  // Lock-up avoidance bits
  localparam int unsigned HW_IMPL_BIT  = 10;
  localparam int unsigned SPC_BIT      = 14;

  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned DATA_TIMEOUT_NS = 3000;
  localparam int unsigned DATA_TIMEOUT_CYC = DATA_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned HOST_GAP_NS     = 1000;
  localparam int unsigned HOST_GAP_CYC =
    (HOST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CORE_NOP_CYC    = 100;

  // Configuration end register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CFG    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_HWIMPL = 8'h0C;
  localparam logic [7:0] OFS_SPC    = 8'h10;
  localparam logic [7:0] OFS_LAT    = 8'h14;
  localparam logic [7:0] OFS_ACR    = 8'h18;

  // Configuration end field positions and reset values
  localparam int unsigned CTRL_RETRY_BIT = 8;
  localparam int unsigned CTRL_CORE_BIT  = 9;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0007;
  localparam logic [31:0] LAT_RST        = 32'h0000_0002;
  localparam logic [31:0] BOOT_CFG       = 32'h0011_0800;
  localparam logic        RCW_HOLD_RST   = 1'b1;
endpackage : sba_pkg

// [hdl/sba_if.sv]
/*
  Link between the arbiter and its configuration/master end.
  Assumes both ends share hclk; all signals are synchronous to it.
*/
`timescale 1ns/1ps
interface sba_if;
  import sba_pkg::*;
  logic [NUM_M-1:0] req;        // Master requests
  logic [NUM_M-1:0] gnt;        // One-cycle grant per accepted address
  logic             dack;       // Data phase done (oldest)
  logic             retry;      // Oldest transaction retried
  logic             timeout;    // Oldest transaction dropped on time-out
  logic             busy;       // Outstanding work or depth change pending
  logic             cfg_we;     // Config write strobe
  logic [31:0]      cfg_wdata;  // Config write data
  logic [31:0]      cfg_rdata;  // Current config register
  logic             rcw_hold;   // Core hold-off strap
  logic             core_fetch; // Core released

  modport dev (input req, dack, retry, cfg_we, cfg_wdata, rcw_hold,
               output gnt, timeout, busy, cfg_rdata, core_fetch);
  modport cfg (output req, dack, retry, cfg_we, cfg_wdata, rcw_hold,
               input gnt, timeout, busy, cfg_rdata, core_fetch);
endinterface : sba_if

// [hdl/sba_arbiter.sv]
/*
  Arbiter end: fixed-priority grant, pipeline depth limit, depth staging,
  data time-out and core hold-off.
  Assumes the far end keeps a transaction's data phase in grant order.
*/
`timescale 1ns/1ps
module sba_arbiter (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Link to configuration end
  sba_if.dev               bus,
  // User side
  output logic             core_fetch_en,
  output logic             timeout_event,
  output logic [1:0]       active_depth
);
  import sba_pkg::*;

  localparam logic [7:0] TO_LAST = 8'(DATA_TIMEOUT_CYC - 1);

  logic [31:0]      arbiter_config_reg;
  logic [1:0]       depth_pend;
  logic             pend_valid;
  logic [2:0]       outst;
  logic [7:0]       to_cnt;
  logic             core_hold;
  logic             strap_done;

  ////////////////////////////////////////////////////////////////////////////
  // Grant and retire decode
  wire              grant_ok  = (outst <= {1'b0, active_depth}) && !pend_valid;
  wire [NUM_M-1:0]  req_ok    = bus.req & {NUM_M{grant_ok}};
  wire [NUM_M-1:0]  gnt_w     = req_ok & ~(req_ok - 3'h1);
  wire              issue     = |gnt_w;
  wire              retire    = (bus.dack | bus.retry) && (outst != 3'h0);
  // Time-out only on a real stalled data phase, never in a depth apply
  wire              to_fire   = (outst != 3'h0) && (to_cnt == TO_LAST)
                                && !retire && !pend_valid;
  wire              drop      = retire | to_fire;
  // Depth swaps only with nothing in flight and no ack or retry this cycle
  wire              apply     = pend_valid && (outst == 3'h0) && !bus.dack
                                && !bus.retry && !issue;
  wire [1:0]        wr_depth  = bus.cfg_wdata[ACR_DEPTH_LSB +: 2];

  assign bus.gnt        = gnt_w;
  assign bus.timeout    = to_fire;
  assign bus.busy       = (outst != 3'h0) | pend_valid;
  assign bus.cfg_rdata  = arbiter_config_reg;
  assign bus.core_fetch = core_fetch_en;

  ////////////////////////////////////////////////////////////////////////////
  // Outstanding count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outst <= 3'h0;
    end else begin
      outst <= outst + {2'h0, issue} - {2'h0, drop};
    end
  end

  // Data-phase watchdog on the oldest transaction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      to_cnt <= 8'h00;
    end else if (drop || apply || outst == 3'h0) begin
      to_cnt <= 8'h00;
    end else begin
      to_cnt <= to_cnt + 8'h01;
    end
  end

  // Registered error event for software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_event <= 1'b0;
    end else begin
      timeout_event <= to_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Config register and staged depth; new depth never lands mid-transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arbiter_config_reg <= ACR_RST;
      depth_pend         <= 2'h0;
      pend_valid         <= 1'b0;
      active_depth       <= 2'h0;
    end else begin
      if (bus.cfg_we) begin
        arbiter_config_reg <= bus.cfg_wdata;
        if (wr_depth != active_depth) begin
          depth_pend <= wr_depth;
          pend_valid <= 1'b1;
        end
      end else if (apply) begin
        active_depth <= depth_pend;
        pend_valid   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core hold-off: strap caught one edge after release, cleared by config
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_hold  <= 1'b1;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      core_hold  <= bus.rcw_hold;
      strap_done <= 1'b1;
    end else if (bus.cfg_we) begin
      core_hold  <= bus.cfg_wdata[ACR_HOLD_BIT];
    end
  end

  assign core_fetch_en = strap_done && !core_hold;
endmodule : sba_arbiter

// [hdl/sba_cfg_end.sv]
/*
  Configuration and master end of the arbiter link, an AHB-Lite slave.
  Loads boot settings, programs depth only on an idle bus, keeps the
  settle gap after each change, and answers data phases after a latency.
  Assumes a single AHB-Lite master; master request pins are asynchronous.
*/
// The AHB-Lite register port and the address map were left to the implementer.
// How it works
// - Arbiter field: 10 below 1:2, 01 above
// - Set both lock-avoidance bits right after boot (left to software; both reset to 0)
// - Arbiter stages new depth safely past acks
// - No false time-out from depth changes
// - Depth changes only with other masters idle
// - Core write: 100-cycle quiet bus window
// - Host write: 1 us gap before traffic
// - Strap holds core from fetching at boot
// - Clearing hold bit releases core fetching
// - Boot sequencer loads initial settings itself
`timescale 1ns/1ps
module sba_cfg_end (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Link to arbiter
  sba_if.cfg                     bus,
  // User side
  input  wire logic [sba_pkg::NUM_M-1:0] master_req,
  output logic [sba_pkg::NUM_M-1:0]      master_gnt,
  output logic                   lock_avoid_on,
  output logic [1:0]             arb_ratio_field
);
  import sba_pkg::*;

  typedef enum logic [1:0] {
    SBA_IDLE  = 2'b00,
    SBA_DRAIN = 2'b01,
    SBA_WRITE = 2'b10,
    SBA_QUIET = 2'b11
  } sba_cfg_e;

  localparam logic [7:0] GAP_HOST = 8'(HOST_GAP_CYC);
  localparam logic [7:0] GAP_CORE = 8'(CORE_NOP_CYC);

  sba_cfg_e          state;
  sba_cfg_e          next_state;
  logic [31:0]       ctrl;
  logic [31:0]       cfg_val;
  logic [31:0]       hw_impl;
  logic [31:0]       spc;
  logic [31:0]       lat;
  logic              cfg_go;
  logic              gap_core;
  logic [7:0]        gap_cnt;
  logic [7:0]        to_count;
  logic [2:0]        outst;
  logic [31:0]       lat_cnt;
  logic [NUM_M-1:0]  req_s1;
  logic [NUM_M-1:0]  req_s2;
  logic              a_wr;
  logic [7:0]        a_addr;
  logic              a_ok;

  ////////////////////////////////////////////////////////////////////////////
  // AHB decode; slave never inserts wait states
  wire        ahb_go    = hsel && hready && htrans[1];
  wire        wr_cfg    = a_wr && a_ok && (a_addr == OFS_CFG);
  wire        known     = (haddr[7:0] <= OFS_ACR) && (haddr[1:0] == 2'h0)
                          && (haddr[31:8] == 24'h0);
  wire [31:0] status    = {13'h0, outst, to_count, 4'h0, gap_core,
                           bus.busy, (state != SBA_IDLE), bus.core_fetch};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Read mux for the address phase
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      OFS_CTRL:   rd_mux = ctrl;
      OFS_CFG:    rd_mux = cfg_val;
      OFS_STATUS: rd_mux = status;
      OFS_HWIMPL: rd_mux = hw_impl;
      OFS_SPC:    rd_mux = spc;
      OFS_LAT:    rd_mux = lat;
      OFS_ACR:    rd_mux = bus.cfg_rdata;
      default:    rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr   <= 1'b0;
      a_addr <= 8'h00;
      a_ok   <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      a_wr   <= ahb_go && hwrite && (hsize == 3'h2);
      a_addr <= haddr[7:0];
      a_ok   <= known;
      if (ahb_go && !hwrite) begin
        hrdata <= known ? rd_mux(haddr[7:0]) : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; boot config preloaded at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= CTRL_RST;
      cfg_val <= BOOT_CFG;
      hw_impl <= 32'h0000_0000;
      spc     <= 32'h0000_0000;
      lat     <= LAT_RST;
    end else if (a_wr && a_ok) begin
      case (a_addr)
        OFS_CTRL:   ctrl    <= hwdata;
        OFS_CFG:    cfg_val <= hwdata;
        OFS_HWIMPL: hw_impl <= hwdata;
        OFS_SPC:    spc     <= hwdata;
        OFS_LAT:    lat     <= hwdata;
        default:    ctrl    <= ctrl;
      endcase
    end
  end

  // Lock-up avoidance is on only when both bits are set
  assign lock_avoid_on   = hw_impl[HW_IMPL_BIT] && spc[SPC_BIT];
  assign arb_ratio_field = cfg_val[ACR_ARB_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Pending config write; boot load starts one at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_go   <= 1'b1;
      gap_core <= 1'b0;
    end else if (wr_cfg) begin
      cfg_go   <= 1'b1; // Set wins over the clear below
      gap_core <= ctrl[CTRL_CORE_BIT];
    end else if (state == SBA_WRITE) begin
      cfg_go   <= 1'b0;
    end
  end

  // Config sequencer: drain, write, settle
  always_comb begin
    next_state = state;
    case (state)
      SBA_IDLE:  if (cfg_go) next_state = SBA_DRAIN;
      SBA_DRAIN: if (!bus.busy && !(|bus.req)) next_state = SBA_WRITE;
      SBA_WRITE: next_state = SBA_QUIET;
      SBA_QUIET: if (gap_cnt == 8'h00 && !bus.busy) next_state = SBA_IDLE;
      default:   next_state = SBA_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SBA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Settle gap: core write keeps the bus quiet for the nop run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_cnt <= 8'h00;
    end else if (state == SBA_WRITE) begin
      gap_cnt <= gap_core ? GAP_CORE : GAP_HOST;
    end else if (gap_cnt != 8'h00) begin
      gap_cnt <= gap_cnt - 8'h01;
    end
  end

  assign bus.cfg_we    = (state == SBA_WRITE);
  assign bus.cfg_wdata = cfg_val;
  assign bus.rcw_hold  = RCW_HOLD_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Master requests: pins synchronised, gated off while config runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_s1 <= '0;
      req_s2 <= '0;
    end else begin
      req_s1 <= master_req;
      req_s2 <= req_s1;
    end
  end

  // Requests blocked during any config step so the bus stays idle
  assign bus.req    = (state == SBA_IDLE && !cfg_go) ?
                      (req_s2 & ctrl[NUM_M-1:0]) : '0;
  assign master_gnt = bus.gnt;

  ////////////////////////////////////////////////////////////////////////////
  // Data phase model: oldest completes after the latency register
  wire data_end = (outst != 3'h0) && (lat_cnt >= lat);
  assign bus.dack  = data_end && !ctrl[CTRL_RETRY_BIT];
  assign bus.retry = data_end && ctrl[CTRL_RETRY_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outst   <= 3'h0;
      lat_cnt <= 32'h0000_0000;
    end else begin
      outst <= outst + {2'h0, |bus.gnt}
               - {2'h0, data_end | bus.timeout};
      if (data_end || bus.timeout || outst == 3'h0) begin
        lat_cnt <= 32'h0000_0000;
      end else begin
        lat_cnt <= lat_cnt + 32'h0000_0001;
      end
    end
  end

  // Time-out error count for software (saturating)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      to_count <= 8'h00;
    end else if (bus.timeout && to_count != 8'hFF) begin
      to_count <= to_count + 8'h01;
    end
  end
endmodule : sba_cfg_end

// [dv/sba_link_sva.sv]
/*
  Checker on the link between arbiter and configuration end.
  Assumes one clock hclk and the active-low asynchronous reset hresetn.
*/
`timescale 1ns/1ps
module sba_link_sva (
  // Clock and reset
  input wire logic                     hclk,
  input wire logic                     hresetn,
  // Link signals
  input wire logic [sba_pkg::NUM_M-1:0] req,
  input wire logic [sba_pkg::NUM_M-1:0] gnt,
  input wire logic                     dack,
  input wire logic                     retry,
  input wire logic                     timeout,
  input wire logic                     busy,
  input wire logic                     cfg_we,
  input wire logic [31:0]              cfg_wdata,
  input wire logic                     core_fetch
);
  import sba_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [7:0] stall;
  ////////////////////////////////////////////////////////////////////////
  // Age of the oldest data phase; cleared whenever it ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stall <= 8'h00;
    else if (!busy || dack || retry || timeout) stall <= 8'h00;
    else if (stall != 8'hFF) stall <= stall + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Grant, ack, configuration and time-out ordering
  a_grant_onehot: assert property (gnt != '0 |-> $onehot(gnt))
    else $error("two grants at once");
  a_grant_requested: assert property ((gnt & ~req) == '0)
    else $error("grant without request");
  a_ack_exclusive: assert property (!(dack && retry))
    else $error("ack and retry together");
  a_write_idle: assert property (cfg_we |-> !busy && gnt == '0)
    else $error("config write on busy link");
  a_write_gap: assert property (cfg_we |=> (gnt == '0)[*8])
    else $error("grant inside settle gap");
  a_hold_kept: assert property (cfg_we && cfg_wdata[ACR_HOLD_BIT] |=> !core_fetch)
    else $error("core fetching while held");
  a_hold_release: assert property (cfg_we && !cfg_wdata[ACR_HOLD_BIT] |=> core_fetch)
    else $error("core not released");
  a_fetch_cause: assert property ($rose(core_fetch) |-> $past(cfg_we))
    else $error("core released without write");
  a_timeout_genuine: assert property (timeout |-> stall >= 8'd20)
    else $error("early time-out");
  a_timeout_bound: assert property (stall < 8'd40)
    else $error("stalled phase never timed out");
endmodule : sba_link_sva

// [dv/test_system_bus_arbiter_pipeline_config.sv]
/*
  Testbench: both arbiter ends joined by the link, driven over AHB-Lite.
  Assumes the hand-over latencies: zero-wait AHB, LAT+1 data phase.
*/
`timescale 1ns/1ps
module test_system_bus_arbiter_pipeline_config;
  import sba_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans, arb_ratio_field, active_depth;
  logic [2:0]  hsize, master_req, master_gnt;
  logic core_fetch_en, timeout_event, lock_avoid_on;
  int errors, check_count, tmo_seen, n;

  sba_if link();
  sba_arbiter sba_arbiter_i(.hclk(hclk), .hresetn(hresetn), .bus(link),
    .core_fetch_en(core_fetch_en), .timeout_event(timeout_event),
    .active_depth(active_depth));
  sba_cfg_end sba_cfg_end_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .bus(link), .master_req(master_req),
    .master_gnt(master_gnt), .lock_avoid_on(lock_avoid_on),
    .arb_ratio_field(arb_ratio_field));
  sba_link_sva sba_link_sva_i(.hclk(hclk), .hresetn(hresetn),
    .req(link.req), .gnt(link.gnt), .dack(link.dack), .retry(link.retry),
    .timeout(link.timeout), .busy(link.busy), .cfg_we(link.cfg_we),
    .cfg_wdata(link.cfg_wdata), .core_fetch(link.core_fetch));

  ////////////////////////////////////////////////////////////////////////
  // Clock and time-out pulse tally
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) if (timeout_event === 1'b1) tmo_seen++;

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait ran out: count it and stop
  task automatic limit(input int lim);
    if (n >= lim) begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask : limit

  ////////////////////////////////////////////////////////////////////////
  // One AHB-Lite single word transfer; waits on hready, never assumes it
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    // Start just after a rising edge, whatever edge the caller stopped on
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    limit(50);
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    limit(50);
    v = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(v, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  // Poll status until the config write in flight has settled
  task automatic cfg_done();
    n = 0;
    do begin ahb(1'b0, OFS_STATUS, 32'h0); n++; end while (v[1] !== 1'b0 && n < 200);
    limit(200);
  endtask : cfg_done

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_boot();
    cfg_done();
    rd_chk(OFS_ACR, BOOT_CFG);
    @(negedge hclk);
    chk({30'h0, arb_ratio_field}, {30'h0, ARB_RATIO_LOW});
    chk({31'h0, core_fetch_en}, 32'h0);
  endtask : t_boot

  task automatic t_lock();
    ahb(1'b1, OFS_SPC, 32'h0);
    ahb(1'b1, OFS_HWIMPL, 32'h1 << HW_IMPL_BIT);
    @(negedge hclk);
    chk({31'h0, lock_avoid_on}, 32'h0);
    ahb(1'b1, OFS_SPC, 32'h1 << SPC_BIT);
    @(negedge hclk);
    chk({31'h0, lock_avoid_on}, 32'h1);
  endtask : t_lock

  // One dma request pulse; ack or retry must come LAT+1 cycles after grant
  task automatic t_xfer(input logic rt);
    ahb(1'b1, OFS_CTRL, {23'h0, rt, 8'h07});
    @(posedge hclk) master_req <= 3'b010;
    @(posedge hclk) master_req <= 3'b000;
    n = 0;
    do begin @(negedge hclk); n++; end while (link.gnt[1] !== 1'b1 && n < 20);
    limit(20);
    chk({29'h0, master_gnt}, 32'h0000_0002);
    n = 0;
    do begin @(negedge hclk); n++; end while (!(link.dack | link.retry) && n < 20);
    chk(n, LAT_RST + 32'h0000_0001);
    chk({31'h0, link.retry}, {31'h0, rt});
  endtask : t_xfer

  // Depth change while two masters keep asking
  task automatic t_depth();
    @(posedge hclk) master_req <= 3'b110;
    ahb(1'b1, OFS_CFG, 32'h0012_0400);
    cfg_done();
    @(posedge hclk) master_req <= 3'b000;
    repeat (20) @(posedge hclk);
    rd_chk(OFS_ACR, 32'h0012_0400);
    @(negedge hclk);
    chk({30'h0, active_depth}, 32'h2);
    chk({30'h0, arb_ratio_field}, {30'h0, ARB_RATIO_HIGH});
    chk(tmo_seen, 0);
  endtask : t_depth

  task automatic t_timeout();
    ahb(1'b1, OFS_LAT, 32'h0000_0028);
    @(posedge hclk) master_req <= 3'b010;
    @(posedge hclk) master_req <= 3'b000;
    repeat (DATA_TIMEOUT_CYC + 10) @(posedge hclk);
    chk(tmo_seen, 1);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk({24'h0, v[15:8]}, 32'h1);
    ahb(1'b1, OFS_LAT, LAT_RST);
  endtask : t_timeout

  task automatic t_release();
    ahb(1'b1, OFS_CFG, 32'h0002_0400);
    n = 0;
    do begin @(negedge hclk); n++; end while (core_fetch_en !== 1'b1 && n < 40);
    chk({31'h0, core_fetch_en}, 32'h1);
    cfg_done();
    chk({31'h0, v[0]}, 32'h1);
    rd_chk(8'h1C, 32'h0);
    ahb(1'b1, OFS_ACR, 32'hFFFF_FFFF);
    rd_chk(OFS_ACR, 32'h0002_0400);
  endtask : t_release

  // Core-flagged write: a waiting master sees no grant inside the nop window
  task automatic t_core();
    ahb(1'b1, OFS_CTRL, 32'h0000_0207);
    ahb(1'b1, OFS_CFG, 32'h0002_0400);
    master_req <= 3'b010;
    n = 0;
    do begin @(negedge hclk); n++; end while (link.gnt[1] !== 1'b1 && n < 300);
    limit(300);
    chk({31'h0, n >= CORE_NOP_CYC}, 32'h0000_0001);
    @(posedge hclk) master_req <= 3'b000;
    repeat (10) @(posedge hclk);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk({29'h0, v[3], v[1:0]}, 32'h0000_0005);
  endtask : t_core

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    master_req = 3'b000;
    errors = 0;
    check_count = 0;
    tmo_seen = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_boot();
    t_lock();
    t_xfer(1'b0);
    t_xfer(1'b1);
    t_depth();
    t_timeout();
    t_release();
    t_core();
    close_out();
  end
endmodule : test_system_bus_arbiter_pipeline_config
